// file: inc/pir_dec_if.sv
`default_nettype none

interface pir_dec_if;
   logic [7:0] ctrl;
   logic       reg_mode;
   logic       wr;
   logic [5:0] idx;
   logic [7:0] ack;

   modport dec  (input ctrl, output reg_mode, output wr, output idx, output ack);
   modport user (output ctrl, input reg_mode, input wr, input idx, input ack);
endinterface

`default_nettype wire

// file: inc/pir_params.svh
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH

// ****************************************
// Control byte layout
// ****************************************
`define PIR_MODE_BIT      7
`define PIR_WRITE_BIT     6
`define PIR_IDX_MSB       5
`define PIR_WRITE_MASK    8'h40

// ****************************************
// Register numbers and values
// ****************************************
`define PIR_IDX_TYPE      6'h08
`define PIR_IDX_FW        6'h09
`define PIR_IDX_KEY       6'h1F
`define PIR_IDX_FEATURE   6'h20
`define PIR_USER_BASE     6'h20
`define PIR_UNLOCK_CODE   16'h1235
`define PIR_KEY_RESET     16'h0000
`define PIR_WORD_RESET    16'h0000
`define PIR_STATUS_RESET  8'h00

`endif

// file: inc/pir_pkg.sv
`default_nettype none
`include "pir_params.svh"

package pir_pkg;
   typedef enum logic [1:0] {
      PIR_ST_LOAD = 2'b00,
      PIR_ST_RUN  = 2'b01
   } pir_state_t;

   typedef logic [15:0] pir_word_t;
   typedef logic [5:0]  pir_idx_t;
endpackage

`default_nettype wire

// file: rtl/pir_decode.sv
`default_nettype none
`include "pir_params.svh"

module pir_decode
   import pir_pkg::*;
(
   pir_dec_if.dec d
);
   assign d.reg_mode = d.ctrl[`PIR_MODE_BIT];
   assign d.wr       = d.reg_mode & d.ctrl[`PIR_WRITE_BIT];
   assign d.idx      = d.ctrl[`PIR_IDX_MSB:0];
   // Receipt: write clears bit 6, read echoes unchanged
   assign d.ack      = d.wr ? (d.ctrl & ~`PIR_WRITE_MASK) : d.ctrl;
endmodule // pir_decode

`default_nettype wire

// file: rtl/pir_nvstore.sv
`default_nettype none
`include "pir_params.svh"

module pir_nvstore
   import pir_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic          i_mclk,
   input  wire logic          i_wen,
   input  wire logic [AW-1:0] i_waddr,
   input  wire pir_word_t     i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output pir_word_t          o_rdata
);
   // ****************************************
   // Retained array
   // ****************************************
   // Deliberately no reset: content must outlive a restart
   pir_word_t mem [DEPTH];

   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = `PIR_WORD_RESET;
      end
   end

   // Plain always: the power-up fill above writes this array too
   always @(posedge i_mclk) begin
      if (i_wen) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   assign o_rdata = mem[i_raddr];
endmodule // pir_nvstore

`default_nettype wire

// file: rtl/pir_top.sv
`default_nettype none
`include "pir_params.svh"

module pir_top
   import pir_pkg::*;
#(
   parameter int        USER_COUNT = 16,
   parameter pir_word_t TYPE_CODE  = 16'h0A5A,  // Arbitrary identity value
   parameter pir_word_t FW_VERSION = 16'h0001
) (
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   input  wire logic       i_image_valid,
   input  wire logic [7:0] i_ctrl_byte,
   input  wire pir_word_t  i_outbound_word,
   output var  logic [7:0] o_status_byte,
   output var  pir_word_t  o_inbound_word,
   output var  logic       o_busy,
   output var  logic       o_unlocked,
   output var  pir_word_t  o_feature_active
);
   localparam int UW = (USER_COUNT > 1) ? $clog2(USER_COUNT) : 1;
   localparam logic [UW-1:0] LAST_USER = UW'(USER_COUNT - 1);

   // ****************************************
   // Decode
   // ****************************************
   function automatic logic is_user(input pir_idx_t idx);
      is_user = (idx >= `PIR_USER_BASE) &&
                ({1'b0, idx} < ({1'b0, `PIR_USER_BASE} + 7'(USER_COUNT)));
   endfunction

   function automatic logic [UW-1:0] user_off(input pir_idx_t idx);
      pir_idx_t off;
      off      = idx - `PIR_USER_BASE;
      user_off = off[UW-1:0];
   endfunction

   pir_dec_if dec_bus ();
   assign dec_bus.ctrl = i_ctrl_byte;

   pir_decode pir_decode_i (
      .d (dec_bus)
   );

   pir_state_t    state_q;
   pir_state_t    state_d;
   logic [UW-1:0] load_idx_q;
   pir_word_t     key_q;
   pir_word_t     work_q   [USER_COUNT];
   pir_word_t     active_q [USER_COUNT];
   pir_word_t     nv_rdata;

   wire running   = (state_q == PIR_ST_RUN);
   wire take      = i_image_valid & running;
   wire take_reg  = take & dec_bus.reg_mode;
   wire do_write  = take_reg & dec_bus.wr;
   wire key_hit   = (dec_bus.idx == `PIR_IDX_KEY);
   wire user_hit  = is_user(dec_bus.idx);
   wire unlocked  = (key_q == `PIR_UNLOCK_CODE);
   wire key_wr    = do_write & key_hit;
   wire user_wr   = do_write & user_hit & unlocked;
   wire [UW-1:0] wr_off = user_off(dec_bus.idx);
   wire load_last = (load_idx_q == LAST_USER);

   // ****************************************
   // Read selection
   // ****************************************
   pir_word_t rd_word;
   always_comb begin
      rd_word = `PIR_WORD_RESET;
      if (key_hit) begin
         rd_word = key_q;
      end else if (dec_bus.idx == `PIR_IDX_TYPE) begin
         rd_word = TYPE_CODE;
      end else if (dec_bus.idx == `PIR_IDX_FW) begin
         rd_word = FW_VERSION;
      end else if (user_hit) begin
         rd_word = work_q[wr_off];
      end
   end

   // ****************************************
   // Restart sequencer
   // ****************************************
   // Reload from retained store so written values act only now
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PIR_ST_LOAD: if (load_last) begin
            state_d = PIR_ST_RUN;
         end
         PIR_ST_RUN:  state_d = PIR_ST_RUN;
         default:     state_d = PIR_ST_LOAD;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q    <= PIR_ST_LOAD;
         load_idx_q <= '0;
      end else begin
         state_q    <= state_d;
         if (!running && !load_last) begin
            load_idx_q <= load_idx_q + UW'(1);
         end
      end
   end

   pir_nvstore #(
      .DEPTH (USER_COUNT),
      .AW    (UW)
   ) pir_nvstore_i (
      .i_mclk  (i_mclk),
      .i_wen   (user_wr),
      .i_waddr (wr_off),
      .i_wdata (i_outbound_word),
      .i_raddr (load_idx_q),
      .o_rdata (nv_rdata)
   );

   // ****************************************
   // User registers: working and active copy
   // ****************************************
   for (genvar g = 0; g < USER_COUNT; g++) begin : g_user
      wire load_me = !running && (load_idx_q == UW'(g));
      wire wr_me   = user_wr && (wr_off == UW'(g));

      always_ff @(posedge i_mclk or negedge i_resetn) begin
         if (!i_resetn) begin
            work_q[g] <= `PIR_WORD_RESET;
         end else if (load_me) begin
            work_q[g] <= nv_rdata;
         end else if (wr_me) begin
            work_q[g] <= i_outbound_word;
         end
      end

      // Only the restart load touches this copy
      always_ff @(posedge i_mclk or negedge i_resetn) begin
         if (!i_resetn) begin
            active_q[g] <= `PIR_WORD_RESET;
         end else if (load_me) begin
            active_q[g] <= nv_rdata;
         end
      end
   end

   // ****************************************
   // Code word
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         key_q <= `PIR_KEY_RESET;
      end else if (key_wr) begin
         key_q <= i_outbound_word;
      end
   end

   // ****************************************
   // Input image
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_status_byte  <= `PIR_STATUS_RESET;
         o_inbound_word <= `PIR_WORD_RESET;
      end else if (take_reg) begin
         o_status_byte <= dec_bus.ack;
         // Word left as is after a write: it carries no meaning then
         if (!dec_bus.wr) begin
            o_inbound_word <= rd_word;
         end
      end else if (take) begin
         o_status_byte  <= i_ctrl_byte;
         o_inbound_word <= `PIR_WORD_RESET;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_busy           <= 1'b1;
         o_unlocked       <= 1'b0;
         o_feature_active <= `PIR_WORD_RESET;
      end else begin
         o_busy           <= (state_d != PIR_ST_RUN);
         o_unlocked       <= unlocked;
         o_feature_active <= active_q[user_off(`PIR_IDX_FEATURE)];
      end
   end
endmodule // pir_top

`default_nettype wire

// file: test/pir_ctrl_model.sv
`default_nettype none
module pir_ctrl_model
   import pir_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_st,
   output logic            o_vld,
   output logic [7:0]      o_ctl,
   output pir_word_t       o_wd,
   output logic            o_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ack;
   initial begin
      o_vld = 1'b0;
      o_ctl = 8'h00;
      o_wd = 16'h0000;
      o_ack = 1'b0;
   end
   task automatic send(input logic [7:0] c, input pir_word_t w);
      ack = (c[7] && c[6]) ? (c & 8'hBF) : c;
      o_ctl = c;
      o_wd = w;
      o_vld = 1'b1;
      for (int k = 0; k < 20; k++) begin
         @(negedge i_mclk);
         if (i_st === ack) break;
      end
      o_ack = 1'b1;
      o_vld = 1'b0;
      // Released word must not look valid
      o_wd = ~w;
      @(negedge i_mclk);
      o_ack = 1'b0;
   endtask
endmodule // pir_ctrl_model
`default_nettype wire

// file: test/pir_properties.sv
`default_nettype none
module pir_properties
   import pir_pkg::*;
(
   input wire logic       i_mclk,
   input wire logic       i_resetn,
   input wire logic       i_image_valid,
   input wire logic [7:0] i_ctrl_byte,
   input wire pir_word_t  i_outbound_word,
   input wire logic [7:0] o_status_byte,
   input wire pir_word_t  o_inbound_word,
   input wire logic       o_busy,
   input wire logic       o_unlocked,
   input wire pir_word_t  o_feature_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   sequence s_take;
      i_image_valid && !o_busy;
   endsequence
   sequence s_key;
      s_take ##0 i_ctrl_byte == 8'hDF;
   endsequence
   a_read_echo: assert property (s_take ##0 i_ctrl_byte[7:6] == 2'b10
      |=> o_status_byte == $past(i_ctrl_byte)) else $error("read receipt wrong");
   a_write_ack: assert property (s_take ##0 i_ctrl_byte[7:6] == 2'b11
      |=> o_status_byte == ($past(i_ctrl_byte) & 8'hBF)) else $error("write receipt wrong");
   a_write_stale: assert property (s_take ##0 i_ctrl_byte[7:6] == 2'b11
      |=> $stable(o_inbound_word)) else $error("data word moved on write");
   a_plain_echo: assert property (s_take ##0 !i_ctrl_byte[7]
      |=> o_status_byte == $past(i_ctrl_byte) && o_inbound_word == 16'h0000) else $error("plain image");
   a_key_unlock: assert property (s_key ##0 i_outbound_word == 16'h1235 |-> ##2 o_unlocked)
      else $error("key did not unlock");
   a_key_relock: assert property (s_key ##0 i_outbound_word != 16'h1235 |-> ##2 !o_unlocked)
      else $error("key did not relock");
   a_load_locked: assert property (o_busy |-> !o_unlocked) else $error("unlocked after restart");
   a_feature_hold: assert property (!o_busy && !$past(o_busy, 3) |-> $stable(o_feature_active))
      else $error("feature changed in run");
endmodule // pir_properties
bind pir_top pir_properties pir_properties_i (.i_mclk(i_mclk), .i_resetn(i_resetn),
   .i_image_valid(i_image_valid), .i_ctrl_byte(i_ctrl_byte), .i_outbound_word(i_outbound_word),
   .o_status_byte(o_status_byte), .o_inbound_word(o_inbound_word), .o_busy(o_busy),
   .o_unlocked(o_unlocked), .o_feature_active(o_feature_active));
`default_nettype wire

// file: test/process_image_register_access_test.sv
`default_nettype none
module process_image_register_access_test
   import pir_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int USERS = 2;
   logic        i_mclk, i_resetn, vld, ack, busy, unl;
   logic [7:0]  ctl, st;
   pir_word_t   wd, inb, feat, v, w;
   logic [24:0] n;
   logic [24:0] exp_q[$];
   int          num_errors = 0;
   int          n_checks = 0;
   int          seed = 32'heecc_0cd2;
   // Arbitrary identity values
   pir_top #(.USER_COUNT(USERS), .TYPE_CODE(16'h0C3C), .FW_VERSION(16'h0102)) pir_top_i (.i_mclk(i_mclk),
      .i_resetn(i_resetn), .i_image_valid(vld), .i_ctrl_byte(ctl), .i_outbound_word(wd),
      .o_status_byte(st), .o_inbound_word(inb), .o_busy(busy), .o_unlocked(unl), .o_feature_active(feat));
   pir_ctrl_model pir_ctrl_model_i (.i_mclk(i_mclk), .i_st(st), .o_vld(vld), .o_ctl(ctl), .o_wd(wd),
      .o_ack(ack));
   task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_w(input pir_word_t g, input pir_word_t e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic req(input logic [7:0] c, input pir_word_t d, input logic rd, input pir_word_t e);
      exp_q.push_back({rd, (c[7] && c[6]) ? (c & 8'hBF) : c, e});
      pir_ctrl_model_i.send(c, d);
   endtask
   task automatic restart;
      i_resetn = 1'b0;
      repeat (8) @(negedge i_mclk);
      i_resetn = 1'b1;
      // Restart load takes one edge per user register
      repeat (USERS - 1) @(negedge i_mclk);
      chk_b({7'h00, busy}, 8'h01);
      @(negedge i_mclk);
      chk_b({7'h00, busy}, 8'h00);
      repeat (3) @(negedge i_mclk);
   endtask
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // Receipt is sampled while the model holds its pulse
   always @(posedge i_mclk) begin
      if (ack === 1'b1 && exp_q.size() > 0) begin
         n = exp_q.pop_front();
         chk_b(st, n[23:16]);
         if (n[24])
            chk_w(inb, n[15:0]);
      end
   end
   initial begin
      #20_000;
      num_errors++;
      complete_run;
   end
   initial begin
      v = 16'($random(seed));
      w = 16'($random(seed));
      restart;
      chk_b({7'h00, unl}, 8'h00);
      chk_w(feat, 16'h0000);
      req(8'h89, v, 1'b1, 16'h0102);
      req(8'h88, ~v, 1'b1, 16'h0C3C);
      req(8'hC9, w, 1'b0, 16'h0000);
      req(8'h89, ~w, 1'b1, 16'h0102);
      req(8'h82, v, 1'b1, 16'h0000);
      $display("test identity done");
      req(8'hE0, v, 1'b0, 16'h0000);
      req(8'hA0, w, 1'b1, 16'h0000);
      $display("test locked done");
      req(8'hDF, 16'h1235, 1'b0, 16'h0000);
      req(8'h9F, v, 1'b1, 16'h1235);
      chk_b({7'h00, unl}, 8'h01);
      req(8'hE0, v, 1'b0, 16'h0000);
      req(8'hE1, w, 1'b0, 16'h0000);
      req(8'hA0, w, 1'b1, v);
      req(8'hA1, v, 1'b1, w);
      chk_w(feat, 16'h0000);
      $display("test unlocked done");
      req(8'hDF, 16'h0000, 1'b0, 16'h0000);
      chk_b({7'h00, unl}, 8'h00);
      req(8'hE0, ~v, 1'b0, 16'h0000);
      req(8'hA0, 16'h0000, 1'b1, v);
      req(8'h05, v, 1'b1, 16'h0000);
      $display("test relock done");
      restart;
      chk_b({7'h00, unl}, 8'h00);
      chk_w(feat, v);
      req(8'hA1, 16'h0000, 1'b1, w);
      $display("test restart done");
      complete_run;
   end
endmodule // process_image_register_access_test
`default_nettype wire
